// ---- logic/gpio_mux_input_qualifier.sv ----
// pin function multiplexer with per-pin input qualifier and axi4-lite registers
// ========================================
// Notes on behaviour
// - each 2-bit select picks plain i/o with 00 after reset and peripheral 1..3 with 01..11.
// - selects of pins 0-15, 16-31 and 32 up sit in the a-low, a-high and b select words.
// - pins 14/15 give trip zone 3/4, serial b transmit/receive, spi b clock/enable.
// - pins 16-19 with 01 route spi a lines; pins 28-31 serial a receive/transmit, can a rx/tx.
// - pin 32 gives i2c data, pwm sync in, start a; pin 33 i2c clock, pwm sync out, start b.
// - a reserved select attaches no peripheral; here the pin is released.
// - each pin has a 2-bit qualifier type field in the qualifier select words.
// - qualifier 00, the reset default, only synchronises the pin to the clock.
// - qualifiers 01 and 10 synchronise and hold the value until the input is stable.
// - the sample period comes from a field in the group control word, one per 8 pins.
// - the window is 3 or 6 samples and the output moves only when all samples agree.
// - qualifier 11 passes the pin with no synchronisation.
// - a peripheral input with no pin selected sits at its own fixed idle level.
`timescale 1ns/1ns
module gpio_mux_input_qualifier
    import gpio_mux_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                nrst_in,
    input  wire logic                s_axi_awvalid_in,
    output logic                     s_axi_awready_out,
    input  wire logic [5:0]          s_axi_awaddr_in,
    input  wire logic                s_axi_wvalid_in,
    output logic                     s_axi_wready_out,
    input  wire logic [31:0]         s_axi_wdata_in,
    input  wire logic [3:0]          s_axi_wstrb_in,
    output logic                     s_axi_bvalid_out,
    input  wire logic                s_axi_bready_in,
    output logic [1:0]               s_axi_bresp_out,
    input  wire logic                s_axi_arvalid_in,
    output logic                     s_axi_arready_out,
    input  wire logic [5:0]          s_axi_araddr_in,
    output logic                     s_axi_rvalid_out,
    input  wire logic                s_axi_rready_in,
    output logic [31:0]              s_axi_rdata_out,
    output logic [1:0]               s_axi_rresp_out,
    input  wire logic [NPIN-1:0]     pin_in,
    output logic [NPIN-1:0]          pin_out,
    output logic [NPIN-1:0]          pin_oe_n_out,
    input  wire periph_drive_t       drive_in,
    output periph_sense_t            sense_out
);
    // 2-bit field of pin p in a flattened select vector
    function automatic logic [1:0] field2(input logic [95:0] v, input int p);
        return v[2*p +: 2];
    endfunction : field2

    // spi line carried by pin p at select s
    function automatic logic [2:0] spi_idx(input int p, input logic [1:0] s);
        if (s == SEL_PERIPH1 && p >= 16 && p <= 19) return 3'(p - 16);
        if (s == SEL_PERIPH3 && (p == 14 || p == 26)) return SPI_B_CLK;
        if (s == SEL_PERIPH3 && (p == 15 || p == 27)) return SPI_B_EN;
        return SPI_NONE;
    endfunction : spi_idx

    logic [31:0]         cfg_ff [NCFG];
    logic [31:0]         nxt_cfg [NCFG];
    logic                aw_full_ff, nxt_aw_full, w_full_ff, nxt_w_full;
    logic [3:0]          aw_idx_ff, nxt_aw_idx;
    logic [31:0]         w_data_ff, nxt_w_data;
    logic [3:0]          w_strb_ff, nxt_w_strb;
    logic                bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0]          bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0]         rdata_ff, nxt_rdata;
    logic [95:0]         sel_all, qsel_all;
    logic [63:0]         ctrl_all, data_all, dir_all;
    logic [NPIN-1:0]     sync1_ff, sync2_ff, qual_ff, nxt_qual, pin_val;
    logic [5:0]          win_ff [NPIN];
    logic [5:0]          nxt_win [NPIN];
    logic [PERIOD_W-1:0] cnt_ff [NGRP];
    logic [PERIOD_W-1:0] nxt_cnt [NGRP];
    logic [NGRP-1:0]     strobe;

    // ========================================
    // flattened views of the configuration words
    assign sel_all  = {cfg_ff[IDX_SEL_B], cfg_ff[IDX_SEL_A_HIGH], cfg_ff[IDX_SEL_A_LOW]};
    assign qsel_all = {cfg_ff[IDX_QSEL_B], cfg_ff[IDX_QSEL_A_HIGH],
                       cfg_ff[IDX_QSEL_A_LOW]};
    assign ctrl_all = {cfg_ff[IDX_CTRL_B], cfg_ff[IDX_CTRL_A]};
    assign data_all = {cfg_ff[IDX_DATA_B], cfg_ff[IDX_DATA_A]};
    assign dir_all  = {cfg_ff[IDX_DIR_B], cfg_ff[IDX_DIR_A]};

    // ========================================
    // axi4-lite slave: one write and one read at a time
    assign s_axi_awready_out = !aw_full_ff && !bvalid_ff;
    assign s_axi_wready_out  = !w_full_ff && !bvalid_ff;
    assign s_axi_arready_out = !rvalid_ff;
    assign s_axi_bvalid_out  = bvalid_ff;
    assign s_axi_bresp_out   = bresp_ff;
    assign s_axi_rvalid_out  = rvalid_ff;
    assign s_axi_rresp_out   = rresp_ff;
    assign s_axi_rdata_out   = rdata_ff;

    // next state of the bus and the register words
    always_comb begin
        logic [3:0] ridx;
        ridx        = s_axi_araddr_in[5:2];
        nxt_cfg     = cfg_ff;
        nxt_aw_full = aw_full_ff;
        nxt_aw_idx  = aw_idx_ff;
        nxt_w_full  = w_full_ff;
        nxt_w_data  = w_data_ff;
        nxt_w_strb  = w_strb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        nxt_rvalid  = rvalid_ff;
        nxt_rresp   = rresp_ff;
        nxt_rdata   = rdata_ff;
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            nxt_aw_full = 1'b1;
            nxt_aw_idx  = s_axi_awaddr_in[5:2];
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            nxt_w_full = 1'b1;
            nxt_w_data = s_axi_wdata_in;
            nxt_w_strb = s_axi_wstrb_in;
        end
        if (aw_full_ff && w_full_ff) begin
            nxt_aw_full = 1'b0;
            nxt_w_full  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = (aw_idx_ff <= IDX_IN_B) ? RESP_OKAY : RESP_SLVERR;
            if (aw_idx_ff < 4'(NCFG)) begin
                for (int b = 0; b < 4; b++) begin
                    if (w_strb_ff[b]) nxt_cfg[aw_idx_ff][8*b +: 8] = w_data_ff[8*b +: 8];
                end
            end
        end
        if (bvalid_ff && s_axi_bready_in) nxt_bvalid = 1'b0;
        if (rvalid_ff && s_axi_rready_in) nxt_rvalid = 1'b0;
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = RESP_OKAY;
            if (ridx < 4'(NCFG)) nxt_rdata = cfg_ff[ridx];
            else if (ridx == IDX_IN_A) nxt_rdata = pin_val[31:0];
            else if (ridx == IDX_IN_B) nxt_rdata = {29'h0, pin_val[NPIN-1:32]};
            else begin
                nxt_rdata = 32'h0;
                nxt_rresp = RESP_SLVERR;
            end
        end
    end

    // bus and register flops, all selects and qualifiers clear at reset
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < NCFG; i++) cfg_ff[i] <= CFG_RESET;
            aw_full_ff <= 1'b0;
            aw_idx_ff  <= 4'h0;
            w_full_ff  <= 1'b0;
            w_data_ff  <= 32'h0;
            w_strb_ff  <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= RESP_OKAY;
            rdata_ff   <= 32'h0;
        end else begin
            cfg_ff     <= nxt_cfg;
            aw_full_ff <= nxt_aw_full;
            aw_idx_ff  <= nxt_aw_idx;
            w_full_ff  <= nxt_w_full;
            w_data_ff  <= nxt_w_data;
            w_strb_ff  <= nxt_w_strb;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            rvalid_ff  <= nxt_rvalid;
            rresp_ff   <= nxt_rresp;
            rdata_ff   <= nxt_rdata;
        end
    end

    // ========================================
    // input qualifier: period counters, sample windows and held values
    always_comb begin
        logic [1:0] qm;
        logic [5:0] w;
        qm = QUAL_SYNC;
        w  = 6'h0;
        for (int g = 0; g < NGRP; g++) begin
            strobe[g]  = (cnt_ff[g] == ctrl_all[PERIOD_W*g +: PERIOD_W]);
            nxt_cnt[g] = strobe[g] ? '0 : cnt_ff[g] + 1'b1;
        end
        for (int p = 0; p < NPIN; p++) begin
            qm          = field2(qsel_all, p);
            nxt_win[p]  = strobe[p / GRP_PINS] ? {win_ff[p][4:0], sync2_ff[p]} : win_ff[p];
            w           = nxt_win[p];
            nxt_qual[p] = qual_ff[p];
            if (strobe[p / GRP_PINS]) begin
                if (qm == QUAL_WIN3 && (&w[2:0] || ~|w[2:0])) nxt_qual[p] = w[0];
                if (qm == QUAL_WIN6 && (&w || ~|w)) nxt_qual[p] = w[0];
            end
            case (qm)
                QUAL_SYNC:  pin_val[p] = sync2_ff[p];
                QUAL_ASYNC: pin_val[p] = pin_in[p];
                default:    pin_val[p] = qual_ff[p];
            endcase
        end
    end

    // two-flop synchroniser, window and counter flops
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            qual_ff  <= '0;
            for (int p = 0; p < NPIN; p++) win_ff[p] <= 6'h0;
            for (int g = 0; g < NGRP; g++) cnt_ff[g] <= '0;
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
            qual_ff  <= nxt_qual;
            win_ff   <= nxt_win;
            cnt_ff   <= nxt_cnt;
        end
    end

    // ========================================
    // pin function mux; loop runs downward so the lowest pin wins an input
    always_comb begin
        logic [1:0] s;
        logic [2:0] k;
        s            = SEL_GPIO;
        k            = SPI_NONE;
        pin_out      = '0;
        pin_oe_n_out = '1;
        sense_out    = SENSE_IDLE;
        for (int p = NPIN - 1; p >= 0; p--) begin
            s = field2(sel_all, p);
            k = spi_idx(p, s);
            if (s == SEL_GPIO) begin
                pin_out[p]      = data_all[p];
                pin_oe_n_out[p] = !dir_all[p];
            end else if (k != SPI_NONE) begin
                pin_out[p]          = drive_in.spi_out[k];
                pin_oe_n_out[p]     = !drive_in.spi_drive[k];
                sense_out.spi_in[k] = pin_val[p];
            end else begin
                case ({8'(p), s})
                    {8'd14, SEL_PERIPH1}: sense_out.trip_zone_in_3 = pin_val[p];
                    {8'd15, SEL_PERIPH1}: sense_out.trip_zone_in_4 = pin_val[p];
                    {8'd14, SEL_PERIPH2}, {8'd18, SEL_PERIPH2}: begin
                        pin_out[p]      = drive_in.serial_b_transmit;
                        pin_oe_n_out[p] = 1'b0;
                    end
                    {8'd15, SEL_PERIPH2}, {8'd19, SEL_PERIPH2}:
                        sense_out.serial_b_receive = pin_val[p];
                    {8'd28, SEL_PERIPH1}: sense_out.serial_a_receive = pin_val[p];
                    {8'd29, SEL_PERIPH1}: begin
                        pin_out[p]      = drive_in.serial_a_transmit;
                        pin_oe_n_out[p] = 1'b0;
                    end
                    {8'd30, SEL_PERIPH1}: sense_out.can_a_receive = pin_val[p];
                    {8'd31, SEL_PERIPH1}: begin
                        pin_out[p]      = drive_in.can_a_transmit;
                        pin_oe_n_out[p] = 1'b0;
                    end
                    {8'd32, SEL_PERIPH1}: begin
                        pin_oe_n_out[p]         = !drive_in.i2c_data_pull_low;
                        sense_out.i2c_data_line = pin_val[p];
                    end
                    {8'd32, SEL_PERIPH2}: sense_out.pwm_sync_input = pin_val[p];
                    {8'd32, SEL_PERIPH3}: begin
                        pin_out[p]      = drive_in.converter_start_a_out;
                        pin_oe_n_out[p] = 1'b0;
                    end
                    {8'd33, SEL_PERIPH1}: begin
                        pin_oe_n_out[p]          = !drive_in.i2c_clock_pull_low;
                        sense_out.i2c_clock_line = pin_val[p];
                    end
                    {8'd33, SEL_PERIPH2}: begin
                        pin_out[p]      = drive_in.pwm_sync_output;
                        pin_oe_n_out[p] = 1'b0;
                    end
                    {8'd33, SEL_PERIPH3}: begin
                        pin_out[p]      = drive_in.converter_start_b_out;
                        pin_oe_n_out[p] = 1'b0;
                    end
                    default: pin_oe_n_out[p] = 1'b1;
                endcase
            end
        end
    end

    // ========================================
    // checks
    sequence bresp_wait;
        s_axi_bvalid_out && !s_axi_bready_in;
    endsequence
    a_reset_select: assert property (@(posedge clk_in) !nrst_in |=> sel_all == '0)
        else $error("selects not cleared by reset");
    a_sync_two: assert property (@(posedge clk_in) disable iff (!nrst_in)
        field2(qsel_all, 0) == QUAL_SYNC && $past(nrst_in) && $past(nrst_in, 2)
        |-> pin_val[0] == $past(pin_in[0], 2))
        else $error("sync path is not two cycles");
    a_raw_pass: assert property (@(posedge clk_in) disable iff (!nrst_in)
        field2(qsel_all, 28) == QUAL_ASYNC |-> pin_val[28] == pin_in[28])
        else $error("unsynchronised path does not follow the pin");
    a_window_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $changed(qual_ff[28])
        |-> $past(strobe[3]) && $past(win_ff[28][1:0]) == {2{qual_ff[28]}})
        else $error("qualified value moved without an agreeing window");
    a_period_gap: assert property (@(posedge clk_in) disable iff (!nrst_in)
        strobe[3] && ctrl_all[31:24] == 8'h03 |=> !strobe[3] [*3] ##1 strobe[3])
        else $error("sample strobe spacing wrong");
    a_trip_route: assert property (@(posedge clk_in) disable iff (!nrst_in)
        field2(sel_all, 14) == SEL_PERIPH1 |-> sense_out.trip_zone_in_3 == pin_val[14])
        else $error("trip zone 3 not routed from pin 14");
    a_idle_level: assert property (@(posedge clk_in) disable iff (!nrst_in)
        field2(sel_all, 14) != SEL_PERIPH1 |-> sense_out.trip_zone_in_3 == 1'b1)
        else $error("unselected trip zone input not idle");
    a_lowest_pin: assert property (@(posedge clk_in) disable iff (!nrst_in)
        field2(sel_all, 15) == SEL_PERIPH2 && field2(sel_all, 19) == SEL_PERIPH2
        |-> sense_out.serial_b_receive == pin_val[15])
        else $error("serial b receive not from lowest pin");
    a_spi_route: assert property (@(posedge clk_in) disable iff (!nrst_in)
        field2(sel_all, 16) == SEL_PERIPH1 |-> pin_out[16] == drive_in.spi_out[0])
        else $error("spi a data out not on pin 16");
    a_i2c_pull: assert property (@(posedge clk_in) disable iff (!nrst_in)
        field2(sel_all, 32) == SEL_PERIPH1
        |-> pin_oe_n_out[32] == !drive_in.i2c_data_pull_low && !pin_out[32])
        else $error("i2c data not open collector");
    a_reserved_off: assert property (@(posedge clk_in) disable iff (!nrst_in)
        field2(sel_all, 34) != SEL_GPIO |-> pin_oe_n_out[34])
        else $error("reserved select drives the pin");
    a_bresp_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
        bresp_wait |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped before ready");
endmodule : gpio_mux_input_qualifier

// ---- logic/gpio_mux_pkg.sv ----
// constants, register map and carrier types of the pin mux and qualifier
package gpio_mux_pkg;
    // ========================================
    // bank shape
    localparam int NPIN     = 35;
    localparam int NGRP     = 5;
    localparam int NCFG     = 12;
    localparam int GRP_PINS = 8;
    // ========================================
    // register indices, byte address is four times the index
    localparam logic [3:0] IDX_SEL_A_LOW   = 4'h0;
    localparam logic [3:0] IDX_SEL_A_HIGH  = 4'h1;
    localparam logic [3:0] IDX_SEL_B       = 4'h2;
    localparam logic [3:0] IDX_QSEL_A_LOW  = 4'h3;
    localparam logic [3:0] IDX_QSEL_A_HIGH = 4'h4;
    localparam logic [3:0] IDX_QSEL_B      = 4'h5;
    localparam logic [3:0] IDX_CTRL_A      = 4'h6;
    localparam logic [3:0] IDX_CTRL_B      = 4'h7;
    localparam logic [3:0] IDX_DATA_A      = 4'h8;
    localparam logic [3:0] IDX_DATA_B      = 4'h9;
    localparam logic [3:0] IDX_DIR_A       = 4'ha;
    localparam logic [3:0] IDX_DIR_B       = 4'hb;
    localparam logic [3:0] IDX_IN_A        = 4'hc;
    localparam logic [3:0] IDX_IN_B        = 4'hd;
    localparam logic [31:0] CFG_RESET      = 32'h0;
    // ========================================
    // field layout and codes
    localparam int PERIOD_W = 8;
    localparam logic [1:0] SEL_GPIO    = 2'h0;
    localparam logic [1:0] SEL_PERIPH1 = 2'h1;
    localparam logic [1:0] SEL_PERIPH2 = 2'h2;
    localparam logic [1:0] SEL_PERIPH3 = 2'h3;
    localparam logic [1:0] QUAL_SYNC   = 2'h0;
    localparam logic [1:0] QUAL_WIN3   = 2'h1;
    localparam logic [1:0] QUAL_WIN6   = 2'h2;
    localparam logic [1:0] QUAL_ASYNC  = 2'h3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ========================================
    // spi line indices
    localparam logic [2:0] SPI_A_DOUT = 3'h0;
    localparam logic [2:0] SPI_A_DIN  = 3'h1;
    localparam logic [2:0] SPI_A_CLK  = 3'h2;
    localparam logic [2:0] SPI_A_EN   = 3'h3;
    localparam logic [2:0] SPI_B_CLK  = 3'h4;
    localparam logic [2:0] SPI_B_EN   = 3'h5;
    localparam logic [2:0] SPI_NONE   = 3'h7;
    // ========================================
    // signals from the peripherals towards the pins
    typedef struct packed {
        logic       serial_b_transmit;
        logic       serial_a_transmit;
        logic       can_a_transmit;
        logic       pwm_sync_output;
        logic       converter_start_a_out;
        logic       converter_start_b_out;
        logic       i2c_data_pull_low;
        logic       i2c_clock_pull_low;
        logic [5:0] spi_out;
        logic [5:0] spi_drive;
    } periph_drive_t;
    // signals from the pins towards the peripherals
    typedef struct packed {
        logic       trip_zone_in_3;
        logic       trip_zone_in_4;
        logic       serial_b_receive;
        logic       serial_a_receive;
        logic       can_a_receive;
        logic       pwm_sync_input;
        logic       i2c_data_line;
        logic       i2c_clock_line;
        logic [5:0] spi_in;
    } periph_sense_t;
    // level each peripheral input sits at with no pin selected
    localparam periph_sense_t SENSE_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0,
                                             1'b1, 1'b1, 6'h00};
endpackage : gpio_mux_pkg

// ---- verif/periph_model.sv ----
// peripheral side model that drives the pin mux peripheral outputs
`timescale 1ns/1ns
module periph_model
    import gpio_mux_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic [4:0] pat_in,
    output periph_drive_t   drive_out = '0
);
    // ========================================
    // outputs change only on a clock edge, as on-chip logic does
    always @(posedge clk_in) begin
        drive_out <= {4{pat_in}};
    end
endmodule : periph_model

// ---- verif/testbench.sv ----
// register level tests of the pin mux and input qualifier
`timescale 1ns/1ns
module testbench
    import gpio_mux_pkg::*;
;
    logic            clk_in = 1'b0, nrst_in = 1'b0;
    logic            s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic            s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    logic [5:0]      s_axi_awaddr_in = 6'h00, s_axi_araddr_in = 6'h00;
    logic [31:0]     s_axi_wdata_in = 32'h0, s_axi_rdata_out;
    logic [3:0]      s_axi_wstrb_in = 4'hf;
    logic            s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    logic            s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0]      s_axi_bresp_out, s_axi_rresp_out;
    logic [NPIN-1:0] pin_out, pin_oe_n_out, ext = '1;
    wire [NPIN-1:0]  pin_in;
    periph_drive_t   drive_in;
    periph_sense_t   sense_out;
    logic [4:0]      pat = 5'h00;
    int              fails = 0, compares = 0;
    // ========================================
    // wire level: block drive when enabled, else board level with pull-up
    assign pin_in = (~pin_oe_n_out & pin_out) | (pin_oe_n_out & ext);
    always #25 clk_in = ~clk_in;
    gpio_mux_input_qualifier i_gpio_mux_input_qualifier (.clk_in, .nrst_in,
        .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_awaddr_in, .s_axi_wvalid_in,
        .s_axi_wready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_bvalid_out,
        .s_axi_bready_in, .s_axi_bresp_out, .s_axi_arvalid_in, .s_axi_arready_out,
        .s_axi_araddr_in, .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out,
        .s_axi_rresp_out, .pin_in, .pin_out, .pin_oe_n_out, .drive_in, .sense_out);
    periph_model i_periph_model (.clk_in, .pat_in(pat), .drive_out(drive_in));
    // ========================================
    // checking and bus tasks
    task chk(input logic [34:0] got, input logic [34:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk
    task end_sim;
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    task tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick
    task guard(input int n);
        if (n >= 100) begin
            fails++;
            end_sim();
        end
    endtask : guard
    task wr(input logic [3:0] i, input logic [31:0] d);
        int  n;
        bit  a, w;
        n = 0;
        a = 1;
        w = 1;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in  <= 1'b1;
        s_axi_awaddr_in  <= {i, 2'h0};
        s_axi_wdata_in   <= d;
        while ((a || w) && n < 100) begin
            @(posedge clk_in);
            n++;
            if (a && s_axi_awready_out === 1'b1) begin
                s_axi_awvalid_in <= 1'b0;
                a = 0;
            end
            if (w && s_axi_wready_out === 1'b1) begin
                s_axi_wvalid_in <= 1'b0;
                w = 0;
            end
        end
        guard(n);
        n = 0;
        // hold off bready so the response has to wait for it
        repeat (2) @(posedge clk_in);
        s_axi_bready_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (s_axi_bvalid_out !== 1'b1 && n < 100);
        guard(n);
        chk(s_axi_bresp_out, RESP_OKAY, "bresp");
        s_axi_bready_in <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] i, input logic [31:0] exp, input logic [1:0] rexp);
        int n;
        n = 0;
        s_axi_arvalid_in <= 1'b1;
        s_axi_araddr_in  <= {i, 2'h0};
        do begin
            @(posedge clk_in);
            n++;
        end while (s_axi_arready_out !== 1'b1 && n < 100);
        guard(n);
        s_axi_arvalid_in <= 1'b0;
        s_axi_rready_in  <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (s_axi_rvalid_out !== 1'b1 && n < 100);
        guard(n);
        chk(s_axi_rdata_out, exp, "rdata");
        chk(s_axi_rresp_out, rexp, "rresp");
        s_axi_rready_in <= 1'b0;
    endtask : rd
    // ========================================
    // main sequence
    initial begin
        tick(20);
        nrst_in <= 1'b1;
        tick(1);
        for (int k = 0; k < 8; k++) rd(k[3:0], CFG_RESET, RESP_OKAY);
        rd(4'he, 32'h0, RESP_SLVERR);
        chk(pin_oe_n_out, '1, "oe reset");
        chk(sense_out, SENSE_IDLE, "idle levels");
        wr(IDX_DIR_A, 32'h1);
        wr(IDX_DATA_A, 32'h1);
        tick(1);
        chk({pin_oe_n_out[0], pin_out[0]}, 2'b01, "gpio out");
        // pin 14 under each peripheral code
        pat <= 5'h10;
        ext[14] <= 1'b0;
        wr(IDX_SEL_A_LOW, 32'h1000_0000);
        tick(4);
        chk(sense_out.trip_zone_in_3, 1'b0, "trip 3");
        wr(IDX_SEL_A_LOW, 32'h2000_0000);
        tick(2);
        chk({pin_oe_n_out[14], pin_out[14]}, {1'b0, drive_in.serial_b_transmit}, "sb tx");
        wr(IDX_SEL_A_LOW, 32'h3000_0000);
        tick(2);
        chk({pin_oe_n_out[14], pin_out[14]}, {1'b0, drive_in.spi_out[4]}, "spi b clk");
        // shared input follows the lowest selected pin
        wr(IDX_SEL_A_LOW, 32'h8000_0000);
        wr(IDX_SEL_A_HIGH, 32'h80);
        ext[15] <= 1'b0;
        ext[19] <= 1'b1;
        tick(4);
        chk(sense_out.serial_b_receive, 1'b0, "low pin wins");
        ext[15] <= 1'b1;
        ext[19] <= 1'b0;
        tick(4);
        chk(sense_out.serial_b_receive, 1'b1, "low pin wins");
        // spi a, serial a and can a routes
        pat <= 5'h0f;
        ext[28] <= 1'b0;
        ext[30] <= 1'b0;
        wr(IDX_SEL_A_HIGH, 32'h5500_0055);
        tick(4);
        chk({pin_out[31], pin_out[29], pin_out[16]}, 3'b111, "a outs");
        chk({pin_oe_n_out[31], pin_oe_n_out[29], pin_oe_n_out[16]}, 3'b000, "a oe");
        chk({sense_out.serial_a_receive, sense_out.can_a_receive}, 2'b00, "a ins");
        // pins 32 and 33 through each code, pin 34 at code 11 only
        wr(IDX_SEL_B, 32'h5);
        tick(1);
        chk({pin_oe_n_out[33:32], pin_out[33:32]}, 4'h0, "i2c pull");
        wr(IDX_SEL_B, 32'ha);
        tick(4);
        chk({sense_out.pwm_sync_input, pin_out[33]}, 2'b11, "pwm sync");
        wr(IDX_SEL_B, 32'h3f);
        tick(1);
        chk(pin_out[33:32], {drive_in.converter_start_b_out, 1'b1}, "starts");
        chk(pin_oe_n_out[34:32], 3'b100, "reserved");
        rd(IDX_IN_B, 32'h5, RESP_OKAY);
        // qualifier: sync delay, async pass, windows
        ext[28] <= 1'b1;
        tick(1);
        chk(sense_out.serial_a_receive, 1'b0, "sync 1");
        tick(1);
        chk(sense_out.serial_a_receive, 1'b1, "sync 2");
        wr(IDX_QSEL_A_HIGH, 32'h0300_0000);
        tick(1);
        ext[28] <= 1'b0;
        #1;
        chk(sense_out.serial_a_receive, 1'b0, "async");
        wr(IDX_CTRL_A, 32'h0300_0000);
        for (int q = 1; q < 3; q++) begin
            wr(IDX_QSEL_A_HIGH, 32'(q) << 24);
            ext[28] <= 1'b1;
            tick(40);
            ext[28] <= 1'b0;
            tick(12 * q - 6);
            ext[28] <= 1'b1;
            tick(30);
            chk(sense_out.serial_a_receive, 1'b1, "glitch held");
            ext[28] <= 1'b0;
            tick(12 * q + 6);
            chk(sense_out.serial_a_receive, 1'b0, "window pass");
        end
        end_sim();
    end
endmodule : testbench
